// ### logic/freq_watch.sv
// Frequency range monitor for channel one
`include "output_select_defs.svh"

module freq_watch #(
    parameter int FREQ_W = `FREQ_W
) (
    input wire logic clock,
    input wire logic resetn,
    input wire output_select_pkg::watch_mode_type mode,
    input wire logic [FREQ_W-1:0] limit,
    input wire logic [FREQ_W-1:0] output_frequency,
    output logic in_range
);
    import output_select_pkg::*;

    logic in_range_q;
    logic in_range_d;

    // ==========================================================
    // Compare against the limit every cycle
    always_comb begin
        unique case (mode)
            watch_disabled: in_range_d = 1'b0;
            watch_below_limit:
                in_range_d = output_frequency <= limit;
            watch_above_limit:
                in_range_d = output_frequency >= limit;
            default: in_range_d = 1'b0;
        endcase
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            in_range_q <= 1'b0;
        end else begin
            in_range_q <= in_range_d;
        end
    end

    assign in_range = in_range_q;

endmodule : freq_watch

// ### logic/output_message_selector.sv
// Message selector for two relay outputs and one transistor output
//
// Contract
// - Codes 13-17: overtemp, current/voltage limit, sequence run, step done.
// - Codes 18, 19, 22: sequence cycle done, sequence paused, run message.
// - Codes 20, 21: count at or over threshold one or two, until cleared.
// - Code 23: an enabled analog input below its 4 mA or 2 V live-zero floor.
// - Code 24: the logic operation result is one.
// - Code 25: PID actual value inside the band of the two limits.
// - Code 26: external brake, switched at the brake threshold.
// - Code 27: current monitoring, switched at its threshold.
// - Code 28: bit 13 of the fieldbus control word.
// - Relay two and transistor use the same codes, defaulting to 3 and 1.
// - Watch one mode: 0 off, 1 up to limit, 2 limit and up; default 0.
// - Code 10: the frequency watch one result.
// - Watch one limit spans 0.00 to the maximum frequency, default 0.00.
// - Relay one defaults to 2; code 0 off, codes 1 to 3 ready, run, fault.
// - One message may feed several outputs, regardless of control mode.
`include "output_select_defs.svh"

module output_message_selector #(
    parameter int SEL_W = `SEL_W,
    parameter int FREQ_W = `FREQ_W,
    parameter int CNT_W = `CNT_W
) (
    input wire logic clock,
    input wire logic resetn,
    input wire logic [3:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [31:0] reg_rdata,
    input wire output_select_pkg::drive_status_type drive_status,
    input wire output_select_pkg::analog_status_type analog_status,
    input wire output_select_pkg::pid_status_type pid_status,
    input wire logic [FREQ_W-1:0] output_frequency,
    input wire logic [FREQ_W-1:0] max_output_frequency,
    input wire logic [CNT_W-1:0] event_count,
    input wire logic [CNT_W-1:0] counter_threshold_one,
    input wire logic [CNT_W-1:0] counter_threshold_two,
    input wire logic counter_clear_input,
    input wire logic [15:0] fieldbus_control_word,
    output logic relay_one_output,
    output logic relay_two_output,
    output logic transistor_output,
    output logic irq
);
    import output_select_pkg::*;

    // ==========================================================
    // Configuration registers
    logic [SEL_W-1:0] relay_one_select_q, relay_one_select_d;
    logic [SEL_W-1:0] relay_two_select_q, relay_two_select_d;
    logic [SEL_W-1:0] transistor_select_q, transistor_select_d;
    watch_mode_type freq_watch_one_mode_q, freq_watch_one_mode_d;
    logic [FREQ_W-1:0] freq_watch_one_limit_q, freq_watch_one_limit_d;
    logic [2:0] event_status_q, event_status_d;
    logic [2:0] event_enable_q, event_enable_d;
    logic [31:0] reg_rdata_q, reg_rdata_d;
    logic [2:0] outputs_q, outputs_d;
    logic count_one_q, count_one_d;
    logic count_two_q, count_two_d;
    logic freq_watch_one;
    logic live_zero_fault;
    logic pid_in_band;
    logic [2:0] rise;

    // Limit clamped to the maximum frequency
    function automatic logic [FREQ_W-1:0] clamp_limit(
        input logic [FREQ_W-1:0] value,
        input logic [FREQ_W-1:0] top
    );
        clamp_limit = (value > top) ? top : value;
    endfunction : clamp_limit

    // Enabled input below its live-zero floor
    function automatic logic below_floor(
        input logic [11:0] value,
        input logic current_mode,
        input logic enable
    );
        logic [11:0] floor;
        floor = current_mode ? `LIVE_ZERO_CURRENT_FLOOR
                             : `LIVE_ZERO_VOLTAGE_FLOOR;
        below_floor = enable && (value < floor);
    endfunction : below_floor

    // Message picked by one selection code
    function automatic logic pick_message(
        input logic [SEL_W-1:0] code,
        input drive_status_type st,
        input logic fw_one,
        input logic cnt_one,
        input logic cnt_two,
        input logic live_zero,
        input logic pid_band,
        input logic fb_bit
    );
        case (code)
            `CODE_OFF: pick_message = 1'b0;
            `CODE_READY: pick_message = st.ready;
            `CODE_RUN_ENABLED: pick_message = st.run_enabled;
            `CODE_FAULT: pick_message = st.fault;
            `CODE_FAULT_INV: pick_message = !st.fault;
            `CODE_ALARM: pick_message = st.alarm;
            `CODE_REVERSE: pick_message = st.reverse;
            `CODE_AT_REFERENCE: pick_message = st.at_reference;
            `CODE_MOTOR_CTRL: pick_message = st.motor_ctrl;
            `CODE_ZERO_FREQ: pick_message = 1'b0;
            `CODE_FREQ_WATCH_ONE: pick_message = fw_one;
            `CODE_FREQ_WATCH_TWO: pick_message = st.freq_watch_two;
            `CODE_PID_DEVIATION: pick_message = st.pid_deviation;
            `CODE_OVERTEMP: pick_message = st.overtemp;
            `CODE_OVERCURRENT_LIMIT:
                pick_message = st.overcurrent_limit;
            `CODE_OVERVOLTAGE_LIMIT:
                pick_message = st.overvoltage_limit;
            `CODE_SEQ_RUNNING: pick_message = st.seq_running;
            `CODE_SEQ_STEP_DONE: pick_message = st.seq_step_done;
            `CODE_SEQ_CYCLE_DONE:
                pick_message = st.seq_cycle_done;
            `CODE_SEQ_PAUSED: pick_message = st.seq_paused;
            `CODE_COUNT_ONE: pick_message = cnt_one;
            `CODE_COUNT_TWO: pick_message = cnt_two;
            `CODE_RUN_MESSAGE: pick_message = st.run_message;
            `CODE_LIVE_ZERO: pick_message = live_zero;
            `CODE_LOGIC_RESULT:
                pick_message = st.logic_operation_result;
            `CODE_PID_BAND: pick_message = pid_band;
            `CODE_BRAKE: pick_message = st.brake_active;
            `CODE_CURRENT_WATCH: pick_message = st.current_watch;
            `CODE_FIELDBUS_BIT: pick_message = fb_bit;
            default: pick_message = 1'b0;
        endcase
    endfunction : pick_message

    // ==========================================================
    // Frequency watch channel one
    freq_watch #(
        .FREQ_W(FREQ_W)
    ) i_freq_watch (
        .clock(clock),
        .resetn(resetn),
        .mode(freq_watch_one_mode_q),
        .limit(clamp_limit(freq_watch_one_limit_q,
                           max_output_frequency)),
        .output_frequency(output_frequency),
        .in_range(freq_watch_one)
    );

    // ==========================================================
    // Message sources
    always_comb begin
        live_zero_fault =
            below_floor(analog_status.analog_input_one,
                        analog_status.input_one_current_mode,
                        analog_status.input_one_live_zero_enable) ||
            below_floor(analog_status.analog_input_two,
                        analog_status.input_two_current_mode,
                        analog_status.input_two_live_zero_enable);
        pid_in_band = (pid_status.pid_actual >= pid_status.pid_band_low) &&
            (pid_status.pid_actual <= pid_status.pid_band_high);
    end

    // Counter indications latch until cleared
    always_comb begin
        count_one_d = count_one_q || (event_count >= counter_threshold_one);
        count_two_d = count_two_q || (event_count >= counter_threshold_two);
        if (counter_clear_input) begin
            count_one_d = 1'b0;
            count_two_d = 1'b0;
        end
    end

    // ==========================================================
    // Output selection, each output registered every cycle
    always_comb begin
        outputs_d[0] = pick_message(relay_one_select_q, drive_status,
            freq_watch_one, count_one_q, count_two_q, live_zero_fault,
            pid_in_band,
            fieldbus_control_word[`FIELDBUS_OUTPUT_BIT]);
        outputs_d[1] = pick_message(relay_two_select_q, drive_status,
            freq_watch_one, count_one_q, count_two_q, live_zero_fault,
            pid_in_band,
            fieldbus_control_word[`FIELDBUS_OUTPUT_BIT]);
        outputs_d[2] = pick_message(transistor_select_q, drive_status,
            freq_watch_one, count_one_q, count_two_q, live_zero_fault,
            pid_in_band,
            fieldbus_control_word[`FIELDBUS_OUTPUT_BIT]);
    end

    // ==========================================================
    // Register access and output change events
    assign rise = outputs_d & ~outputs_q;

    always_comb begin
        relay_one_select_d = relay_one_select_q;
        relay_two_select_d = relay_two_select_q;
        transistor_select_d = transistor_select_q;
        freq_watch_one_mode_d = freq_watch_one_mode_q;
        freq_watch_one_limit_d = freq_watch_one_limit_q;
        event_enable_d = event_enable_q;
        event_status_d = event_status_q;
        reg_rdata_d = 32'h0000_0000;
        if (reg_write) begin
            unique case (reg_addr)
                `REG_RELAY_ONE_SELECT:
                    relay_one_select_d = reg_wdata[SEL_W-1:0];
                `REG_RELAY_TWO_SELECT:
                    relay_two_select_d = reg_wdata[SEL_W-1:0];
                `REG_TRANSISTOR_SELECT:
                    transistor_select_d = reg_wdata[SEL_W-1:0];
                `REG_FREQ_WATCH_ONE_MODE:
                    freq_watch_one_mode_d = watch_mode_type'(reg_wdata[1:0]);
                `REG_FREQ_WATCH_ONE_LIMIT:
                    freq_watch_one_limit_d = reg_wdata[FREQ_W-1:0];
                `REG_EVENT_CLEAR:
                    event_status_d = event_status_q & ~reg_wdata[2:0];
                `REG_EVENT_ENABLE:
                    event_enable_d = reg_wdata[2:0];
                default: ;
            endcase
        end
        // Set wins over a clear in the same cycle
        event_status_d = event_status_d | rise;
        if (reg_read) begin
            unique case (reg_addr)
                `REG_RELAY_ONE_SELECT:
                    reg_rdata_d = 32'(relay_one_select_q);
                `REG_RELAY_TWO_SELECT:
                    reg_rdata_d = 32'(relay_two_select_q);
                `REG_TRANSISTOR_SELECT:
                    reg_rdata_d = 32'(transistor_select_q);
                `REG_FREQ_WATCH_ONE_MODE:
                    reg_rdata_d = 32'(freq_watch_one_mode_q);
                `REG_FREQ_WATCH_ONE_LIMIT:
                    reg_rdata_d = 32'(freq_watch_one_limit_q);
                `REG_OUTPUT_STATE: reg_rdata_d = 32'(outputs_q);
                `REG_EVENT_STATUS: reg_rdata_d = 32'(event_status_q);
                `REG_EVENT_ENABLE: reg_rdata_d = 32'(event_enable_q);
                default: ;
            endcase
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            relay_one_select_q <= `RELAY_ONE_SELECT_RESET;
            relay_two_select_q <= `RELAY_TWO_SELECT_RESET;
            transistor_select_q <= `TRANSISTOR_SELECT_RESET;
            freq_watch_one_mode_q <= watch_disabled;
            freq_watch_one_limit_q <= `FREQ_WATCH_ONE_LIMIT_RESET;
            event_status_q <= 3'h0;
            event_enable_q <= 3'h0;
            reg_rdata_q <= 32'h0000_0000;
            outputs_q <= 3'h0;
            count_one_q <= 1'b0;
            count_two_q <= 1'b0;
        end else begin
            relay_one_select_q <= relay_one_select_d;
            relay_two_select_q <= relay_two_select_d;
            transistor_select_q <= transistor_select_d;
            freq_watch_one_mode_q <= freq_watch_one_mode_d;
            freq_watch_one_limit_q <= freq_watch_one_limit_d;
            event_status_q <= event_status_d;
            event_enable_q <= event_enable_d;
            reg_rdata_q <= reg_rdata_d;
            outputs_q <= outputs_d;
            count_one_q <= count_one_d;
            count_two_q <= count_two_d;
        end
    end

    assign reg_rdata = reg_rdata_q;
    assign relay_one_output = outputs_q[0];
    assign relay_two_output = outputs_q[1];
    assign transistor_output = outputs_q[2];
    assign irq = |(event_status_q & event_enable_q);

endmodule : output_message_selector

// ### pkg/output_select_defs.svh
// Constants of the digital output message selector
`ifndef OUTPUT_SELECT_DEFS_SVH
`define OUTPUT_SELECT_DEFS_SVH

`define SEL_W 5
`define FREQ_W 16
`define CNT_W 16
`define ANA_W 12

`define RELAY_ONE_SELECT_RESET 5'h02
`define RELAY_TWO_SELECT_RESET 5'h03
`define TRANSISTOR_SELECT_RESET 5'h01
`define FREQ_WATCH_ONE_MODE_RESET 2'h0
`define FREQ_WATCH_ONE_LIMIT_RESET 16'h0000

`define CODE_OFF 5'h00
`define CODE_READY 5'h01
`define CODE_RUN_ENABLED 5'h02
`define CODE_FAULT 5'h03
`define CODE_FAULT_INV 5'h04
`define CODE_ALARM 5'h05
`define CODE_REVERSE 5'h06
`define CODE_AT_REFERENCE 5'h07
`define CODE_MOTOR_CTRL 5'h08
`define CODE_ZERO_FREQ 5'h09
`define CODE_FREQ_WATCH_ONE 5'h0a
`define CODE_FREQ_WATCH_TWO 5'h0b
`define CODE_PID_DEVIATION 5'h0c
`define CODE_OVERTEMP 5'h0d
`define CODE_OVERCURRENT_LIMIT 5'h0e
`define CODE_OVERVOLTAGE_LIMIT 5'h0f
`define CODE_SEQ_RUNNING 5'h10
`define CODE_SEQ_STEP_DONE 5'h11
`define CODE_SEQ_CYCLE_DONE 5'h12
`define CODE_SEQ_PAUSED 5'h13
`define CODE_COUNT_ONE 5'h14
`define CODE_COUNT_TWO 5'h15
`define CODE_RUN_MESSAGE 5'h16
`define CODE_LIVE_ZERO 5'h17
`define CODE_LOGIC_RESULT 5'h18
`define CODE_PID_BAND 5'h19
`define CODE_BRAKE 5'h1a
`define CODE_CURRENT_WATCH 5'h1b
`define CODE_FIELDBUS_BIT 5'h1c

`define FIELDBUS_OUTPUT_BIT 13

// Live-zero floors as raw converter counts (full scale 20 mA / 10 V)
`define LIVE_ZERO_CURRENT_FLOOR 12'h0333
`define LIVE_ZERO_VOLTAGE_FLOOR 12'h0333

`define REG_RELAY_ONE_SELECT 4'h0
`define REG_RELAY_TWO_SELECT 4'h1
`define REG_TRANSISTOR_SELECT 4'h2
`define REG_FREQ_WATCH_ONE_MODE 4'h3
`define REG_FREQ_WATCH_ONE_LIMIT 4'h4
`define REG_OUTPUT_STATE 4'h5
`define REG_EVENT_STATUS 4'h6
`define REG_EVENT_CLEAR 4'h7
`define REG_EVENT_ENABLE 4'h8

`endif

// ### pkg/output_select_pkg.sv
// Types of the digital output message selector
package output_select_pkg;

    typedef enum logic [1:0] {
        watch_disabled,
        watch_below_limit,
        watch_above_limit,
        watch_reserved
    } watch_mode_type;

    typedef struct packed {
        logic ready;
        logic run_enabled;
        logic fault;
        logic alarm;
        logic reverse;
        logic at_reference;
        logic motor_ctrl;
        logic freq_watch_two;
        logic pid_deviation;
        logic overtemp;
        logic overcurrent_limit;
        logic overvoltage_limit;
        logic seq_running;
        logic seq_step_done;
        logic seq_cycle_done;
        logic seq_paused;
        logic run_message;
        logic logic_operation_result;
        logic brake_active;
        logic current_watch;
    } drive_status_type;

    typedef struct packed {
        logic [11:0] analog_input_one;
        logic [11:0] analog_input_two;
        logic input_one_current_mode;
        logic input_two_current_mode;
        logic input_one_live_zero_enable;
        logic input_two_live_zero_enable;
    } analog_status_type;

    typedef struct packed {
        logic [15:0] pid_actual;
        logic [15:0] pid_band_low;
        logic [15:0] pid_band_high;
    } pid_status_type;

endpackage : output_select_pkg

// ### sim/output_message_selector_sva.sv
// Port assertions for the output message selector
`include "output_select_defs.svh"

module output_message_selector_sva (
    input wire logic clock,
    input wire logic resetn,
    input wire logic [3:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [31:0] reg_rdata,
    input wire output_select_pkg::drive_status_type drive_status,
    input wire logic [15:0] fieldbus_control_word,
    input wire logic relay_one_output,
    input wire logic relay_two_output,
    input wire logic transistor_output
);
    timeunit 1ns;
    timeprecision 1ps;
    import output_select_pkg::*;

    // ==========================================================
    // Shadow select registers
    logic [4:0] s1_q;
    logic [4:0] s2_q;
    logic [4:0] s3_q;

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            s1_q <= `RELAY_ONE_SELECT_RESET;
            s2_q <= `RELAY_TWO_SELECT_RESET;
            s3_q <= `TRANSISTOR_SELECT_RESET;
        end else if (reg_write) begin
            if (reg_addr == `REG_RELAY_ONE_SELECT) s1_q <= reg_wdata[4:0];
            if (reg_addr == `REG_RELAY_TWO_SELECT) s2_q <= reg_wdata[4:0];
            if (reg_addr == `REG_TRANSISTOR_SELECT) s3_q <= reg_wdata[4:0];
        end
    end

    // ==========================================================
    // Assertions
    default clocking @(posedge clock); endclocking
    default disable iff (!resetn);

    chk_rdata_idle: assert property (
        !$past(reg_read) |-> reg_rdata == 32'h0000_0000)
        else $error("read data not zero outside read slot");
    chk_select_readback: assert property (
        reg_read && reg_addr == 4'h1 |=> reg_rdata == {27'h000_0000, s2_q})
        else $error("relay two select reads back wrong");
    chk_reset_quiet: assert property (
        $rose(resetn) |-> !relay_one_output && !relay_two_output
            && !transistor_output)
        else $error("outputs active right after reset");
    chk_code_overtemp: assert property (
        $past(s1_q) == `CODE_OVERTEMP |->
            relay_one_output == $past(drive_status.overtemp))
        else $error("relay one does not follow overtemperature");
    chk_code_logic: assert property (
        $past(s1_q) == `CODE_LOGIC_RESULT |->
            relay_one_output == $past(drive_status.logic_operation_result))
        else $error("relay one does not follow logic result");
    chk_code_off: assert property (
        $past(s1_q) == `CODE_OFF |-> !relay_one_output)
        else $error("relay one active with code zero");
    chk_remote_bit: assert property (
        $past(s2_q) == `CODE_FIELDBUS_BIT |->
            relay_two_output == $past(fieldbus_control_word[13]))
        else $error("relay two does not follow fieldbus bit");
    chk_run_message: assert property (
        $past(s3_q) == `CODE_RUN_MESSAGE |->
            transistor_output == $past(drive_status.run_message))
        else $error("transistor does not follow run message");
    chk_code_unused: assert property (
        $past(s3_q) > 5'h1c |-> !transistor_output)
        else $error("transistor active with unused code");
endmodule : output_message_selector_sva

bind output_message_selector output_message_selector_sva
    i_output_message_selector_sva (
    .clock(clock),
    .resetn(resetn),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_write(reg_write),
    .reg_read(reg_read),
    .reg_rdata(reg_rdata),
    .drive_status(drive_status),
    .fieldbus_control_word(fieldbus_control_word),
    .relay_one_output(relay_one_output),
    .relay_two_output(relay_two_output),
    .transistor_output(transistor_output)
);

// ### sim/output_message_selector_tb.sv
// Self-checking testbench of the output message selector
`include "output_select_defs.svh"

`define check_eq(got, exp, msg) \
    begin \
        samples_checked++; \
        if ((got) !== (exp)) begin \
            bad_count++; \
            $display("MISMATCH %0t %s", $time, msg); \
        end \
    end

module output_message_selector_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import output_select_pkg::*;

    // ==========================================================
    // Stimulus and observed signals
    logic clock = 1'b0;
    logic resetn = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [31:0] reg_wdata = 32'h0000_0000;
    logic reg_write = 1'b0;
    logic reg_read = 1'b0;
    logic counter_clear_input = 1'b0;
    drive_status_type drive_status = '0;
    analog_status_type analog_status = '0;
    pid_status_type pid_status = '0;
    logic [15:0] output_frequency = 16'h0000;
    logic [15:0] max_output_frequency = 16'h1388;
    logic [15:0] event_count = 16'h0000;
    logic [15:0] counter_threshold_one = 16'h0005;
    logic [15:0] counter_threshold_two = 16'h000a;
    logic [15:0] fieldbus_control_word = 16'h0000;
    logic [31:0] reg_rdata;
    logic relay_one_output;
    logic relay_two_output;
    logic transistor_output;
    logic irq;
    logic [3:0] outs;
    int bad_count = 0;
    int samples_checked = 0;

    assign outs = {irq, relay_one_output, relay_two_output, transistor_output};

    output_message_selector i_output_message_selector (
        .clock(clock),
        .resetn(resetn),
        .reg_addr(reg_addr),
        .reg_wdata(reg_wdata),
        .reg_write(reg_write),
        .reg_read(reg_read),
        .reg_rdata(reg_rdata),
        .drive_status(drive_status),
        .analog_status(analog_status),
        .pid_status(pid_status),
        .output_frequency(output_frequency),
        .max_output_frequency(max_output_frequency),
        .event_count(event_count),
        .counter_threshold_one(counter_threshold_one),
        .counter_threshold_two(counter_threshold_two),
        .counter_clear_input(counter_clear_input),
        .fieldbus_control_word(fieldbus_control_word),
        .relay_one_output(relay_one_output),
        .relay_two_output(relay_two_output),
        .transistor_output(transistor_output),
        .irq(irq)
    );

    initial begin
        forever #12.5 clock = ~clock;
    end

    // ==========================================================
    // Bus and comparison helpers
    task wr(input logic [3:0] a, input logic [31:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clock);
        reg_write <= 1'b0;
        @(posedge clock);
    endtask : wr

    task rd_eq(input logic [3:0] a, input logic [31:0] e);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clock);
        reg_read <= 1'b0;
        #1;
        `check_eq(reg_rdata, e, "register read")
        @(posedge clock);
    endtask : rd_eq

    // Compares irq and the three outputs as one word
    task out_eq(input logic [3:0] e);
        repeat (3) @(posedge clock);
        #1;
        `check_eq(outs, e, "output levels")
        @(posedge clock);
    endtask : out_eq

    // ==========================================================
    // Scenarios
    task test_defaults;
        rd_eq(4'h0, 32'h0000_0002);
        rd_eq(4'h1, 32'h0000_0003);
        rd_eq(4'h2, 32'h0000_0001);
        rd_eq(4'h3, 32'h0000_0000);
        rd_eq(4'h4, 32'h0000_0000);
    endtask : test_defaults

    // One status bit per code; the last code uses the fieldbus bit
    task test_codes;
        drive_status_type src [21] = '{20'h8_0000, 20'h4_0000, 20'h2_0000,
            20'h1_0000, 20'h0_8000, 20'h0_4000, 20'h0_2000, 20'h0_1000,
            20'h0_0800, 20'h0_0400, 20'h0_0200, 20'h0_0100, 20'h0_0080,
            20'h0_0040, 20'h0_0020, 20'h0_0010, 20'h0_0008, 20'h0_0004,
            20'h0_0002, 20'h0_0001, 20'h0_0000};
        logic [4:0] codes [21] = '{5'h01, 5'h02, 5'h03, 5'h05, 5'h06,
            5'h07, 5'h08, 5'h0b, 5'h0c, 5'h0d, 5'h0e, 5'h0f, 5'h10, 5'h11,
            5'h12, 5'h13, 5'h16, 5'h18, 5'h1a, 5'h1b, 5'h1c};
        wr(4'h2, 32'h0000_0000);
        foreach (codes[i]) begin
            wr(4'h0, {27'h000_0000, codes[i]});
            wr(4'h1, {27'h000_0000, codes[i]});
            drive_status <= src[i];
            fieldbus_control_word[`FIELDBUS_OUTPUT_BIT] <= (i == 20);
            out_eq(4'b0110);
            drive_status <= '0;
            fieldbus_control_word <= 16'h0000;
            out_eq(4'b0000);
        end
    endtask : test_codes

    task test_unused;
        drive_status <= '1;
        fieldbus_control_word <= 16'hffff;
        wr(4'h0, 32'h0000_0000);
        wr(4'h1, 32'h0000_001e);
        wr(4'h2, 32'h0000_003d);
        rd_eq(4'h2, 32'h0000_001d);
        out_eq(4'b0000);
        wr(4'h2, 32'h0000_0016);
        out_eq(4'b0001);
        drive_status <= '0;
        fieldbus_control_word <= 16'h0000;
        out_eq(4'b0000);
    endtask : test_unused

    task test_counter;
        event_count <= 16'h0004;
        wr(4'h0, 32'h0000_0014);
        wr(4'h1, 32'h0000_0015);
        wr(4'h2, 32'h0000_0000);
        out_eq(4'b0000);
        event_count <= 16'h0005;
        out_eq(4'b0100);
        event_count <= 16'h000a;
        out_eq(4'b0110);
        counter_clear_input <= 1'b1;
        event_count <= 16'h0000;
        out_eq(4'b0000);
        counter_clear_input <= 1'b0;
        out_eq(4'b0000);
    endtask : test_counter

    task test_live_zero;
        wr(4'h0, 32'h0000_0017);
        analog_status.input_one_live_zero_enable <= 1'b1;
        analog_status.analog_input_one <= 12'h332;
        out_eq(4'b0100);
        analog_status.analog_input_one <= 12'h333;
        out_eq(4'b0000);
        analog_status.input_two_current_mode <= 1'b1;
        analog_status.input_two_live_zero_enable <= 1'b1;
        out_eq(4'b0100);
        analog_status.input_two_live_zero_enable <= 1'b0;
        out_eq(4'b0000);
    endtask : test_live_zero

    task test_pid;
        logic [15:0] act [4] = '{16'h0064, 16'h00c8, 16'h00c9, 16'h0063};
        logic [3:0] exp [4] = '{4'b0100, 4'b0100, 4'b0000, 4'b0000};
        pid_status.pid_band_low <= 16'h0064;
        pid_status.pid_band_high <= 16'h00c8;
        wr(4'h0, 32'h0000_0019);
        foreach (act[i]) begin
            pid_status.pid_actual <= act[i];
            out_eq(exp[i]);
        end
    endtask : test_pid

    task test_freq;
        logic [1:0] mode [5] = '{2'h1, 2'h1, 2'h2, 2'h2, 2'h0};
        logic [15:0] freq [5] = '{16'h03e8, 16'h03e9, 16'h03e8, 16'h03e7,
            16'h03e8};
        logic [3:0] exp [5] = '{4'b0100, 4'b0000, 4'b0100, 4'b0000, 4'b0000};
        wr(4'h0, 32'h0000_000a);
        wr(4'h4, 32'h0000_03e8);
        rd_eq(4'h4, 32'h0000_03e8);
        foreach (mode[i]) begin
            wr(4'h3, {30'h0000_0000, mode[i]});
            output_frequency <= freq[i];
            out_eq(exp[i]);
        end
    endtask : test_freq

    task test_irq;
        wr(4'h1, 32'h0000_0000);
        wr(4'h0, 32'h0000_000d);
        wr(4'h7, 32'h0000_0007);
        wr(4'h8, 32'h0000_0001);
        drive_status.overtemp <= 1'b1;
        out_eq(4'b1100);
        rd_eq(4'h6, 32'h0000_0001);
        rd_eq(4'h5, 32'h0000_0001);
        drive_status.overtemp <= 1'b0;
        wr(4'h7, 32'h0000_0001);
        out_eq(4'b0000);
        wr(4'h8, 32'h0000_0000);
        drive_status.overtemp <= 1'b1;
        out_eq(4'b0100);
        rd_eq(4'h6, 32'h0000_0001);
        drive_status.overtemp <= 1'b0;
        wr(4'hf, 32'hffff_ffff);
        rd_eq(4'hf, 32'h0000_0000);
    endtask : test_irq

    // ==========================================================
    // Sequence, verdict and watchdog
    task complete_run;
        $display("Checks %0d, mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : complete_run

    initial begin
        repeat (10) @(posedge clock);
        resetn <= 1'b1;
        test_defaults();
        test_codes();
        test_unused();
        test_counter();
        test_live_zero();
        test_pid();
        test_freq();
        test_irq();
        complete_run();
    end

    initial begin
        repeat (20000) @(posedge clock);
        bad_count++;
        complete_run();
    end
endmodule : output_message_selector_tb
